// File: logic/wtba_consts.svh
`ifndef WTBA_CONSTS_SVH
`define WTBA_CONSTS_SVH

// ----------------------------------------------------------------
// register byte offsets on the apb port
// ----------------------------------------------------------------
`define WTBA_OFS_LVL_CPU 12'h000
`define WTBA_OFS_LVL_PCIE 12'h004
`define WTBA_OFS_LVL_CSR 12'h008
`define WTBA_OFS_ENABLE 12'h04c
`define WTBA_OFS_PERIOD 12'h050
`define WTBA_OFS_TOK_CPU 12'h054
`define WTBA_OFS_TOK_PCIE 12'h058
`define WTBA_OFS_TOK_CSR 12'h05c
`define WTBA_OFS_STATUS 12'h060

// ----------------------------------------------------------------
// field positions and widths
// ----------------------------------------------------------------
`define WTBA_LVL_W 4
`define WTBA_TOK_W 16
`define WTBA_EN_BIT 0
`define WTBA_ST_TOK_LSB 0
`define WTBA_ST_GNT_LSB 4

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define WTBA_RST_LVL_CPU 4'he
`define WTBA_RST_LVL_PCIE 4'hd
`define WTBA_RST_LVL_CSR 4'hc
`define WTBA_RST_ENABLE 1'h0
`define WTBA_RST_PERIOD 16'hffff
`define WTBA_RST_TOKENS 16'h0fff

`endif

// File: logic/wtba_pkg.sv
package wtba_pkg;
  // number of bus masters: cpu, pcie bridge, csr access
  localparam int unsigned WTBA_NUM_MST = 3;

  // apb request, driven by the bus master
  typedef struct packed {
    logic [11:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
  } wtba_apb_req_t;

  // apb response, driven by this block
  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } wtba_apb_rsp_t;

  // register selected by an address
  typedef enum logic [3:0] {
    WTBA_SEL_NONE,
    WTBA_SEL_LVL0,
    WTBA_SEL_LVL1,
    WTBA_SEL_LVL2,
    WTBA_SEL_ENABLE,
    WTBA_SEL_PERIOD,
    WTBA_SEL_TOK0,
    WTBA_SEL_TOK1,
    WTBA_SEL_TOK2,
    WTBA_SEL_STATUS
  } wtba_sel_t;
endpackage

// File: logic/wtba_token_ctr.sv
`timescale 1ns/10ps
`include "wtba_consts.svh"
// one master's token counter
module wtba_token_ctr (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // control from the arbiter
  input wire logic refresh,
  input wire logic [15:0] budget,
  input wire logic use_bus,
  // state
  output logic [15:0] tokens,
  output logic [15:0] budget_live,
  output logic has_tokens
);
  import wtba_pkg::*;

  logic [15:0] tokens_r, tokens_nxt; // tokens left this period
  logic [15:0] live_r, live_nxt; // budget latched at last refresh

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    tokens_nxt = tokens_r;
    live_nxt = live_r;
    if (refresh) begin
      // new budgets only land here, so a mid-period write waits
      live_nxt = budget;
      tokens_nxt = budget;
    end else if (use_bus && tokens_r != 16'h0000) begin
      tokens_nxt = 16'(tokens_r - 16'h0001);
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tokens_r <= `WTBA_RST_TOKENS;
      live_r <= `WTBA_RST_TOKENS;
    end else begin
      tokens_r <= tokens_nxt;
      live_r <= live_nxt;
    end
  end

  assign tokens = tokens_r;
  assign budget_live = live_r;
  // zero budget means unlimited, otherwise exhausted at zero
  assign has_tokens = (live_r == 16'h0000) || (tokens_r != 16'h0000);
endmodule // wtba_token_ctr

// File: logic/wtba_arbiter.sv
// The implementer's own choices: register access over APB and the register addresses.
`timescale 1ns/10ps
`include "wtba_consts.svh"
// How it works
// - enabled: reload every token counter each period
// - period length is 16 bits, resets ffff
// - each bus-use cycle outside a refresh cycle spends one token, stopping at zero; in a refresh cycle the reload wins
// - out of tokens means low priority
// - token holders beat exhausted masters at each arbitration point; an owner keeps the bus while it requests
// - one enable bit, off after reset
// - per-master 16-bit budget, resets 0fff
// - zero budget means never exhausted
// - highest 4-bit priority level wins
module wtba_arbiter
  import wtba_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // register port
  input wire wtba_pkg::wtba_apb_req_t apb_req,
  output wtba_pkg::wtba_apb_rsp_t apb_rsp,
  // shared bus masters
  input wire logic [2:0] bus_req,
  output logic [2:0] bus_grant
);
  import wtba_pkg::*;

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic rst_meta_r; // first stage, read only by the second
  logic rst_n; // synchronised reset used everywhere

  // release is synchronous so no flop sees a runt reset edge
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_r <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n <= rst_meta_r;
    end
  end

  // ----------------------------------------------------------------
  // helper functions
  // ----------------------------------------------------------------
  // address decode, shared by the read and the write path
  function automatic wtba_sel_t decode(input logic [11:0] addr);
    wtba_sel_t s;
    s = WTBA_SEL_NONE;
    if (addr == `WTBA_OFS_LVL_CPU) begin
      s = WTBA_SEL_LVL0;
    end else if (addr == `WTBA_OFS_LVL_PCIE) begin
      s = WTBA_SEL_LVL1;
    end else if (addr == `WTBA_OFS_LVL_CSR) begin
      s = WTBA_SEL_LVL2;
    end else if (addr == `WTBA_OFS_ENABLE) begin
      s = WTBA_SEL_ENABLE;
    end else if (addr == `WTBA_OFS_PERIOD) begin
      s = WTBA_SEL_PERIOD;
    end else if (addr == `WTBA_OFS_TOK_CPU) begin
      s = WTBA_SEL_TOK0;
    end else if (addr == `WTBA_OFS_TOK_PCIE) begin
      s = WTBA_SEL_TOK1;
    end else if (addr == `WTBA_OFS_TOK_CSR) begin
      s = WTBA_SEL_TOK2;
    end else if (addr == `WTBA_OFS_STATUS) begin
      s = WTBA_SEL_STATUS;
    end
    return s;
  endfunction

  // pick the winner: token class first, then level, then lowest index
  function automatic logic [2:0] pick(
    input logic [2:0] req,
    input logic [2:0] tok_ok,
    input logic [11:0] lvls
  );
    logic [4:0] best;
    logic [4:0] score;
    logic [2:0] win;
    best = 5'h00;
    win = 3'b000;
    for (int i = 0; i < 3; i++) begin
      // token bit on top keeps holders ahead of exhausted ones
      score = {tok_ok[i], lvls[i*4 +: 4]};
      if (req[i] && (win == 3'b000 || score > best)) begin
        best = score;
        win = 3'b000;
        win[i] = 1'b1;
      end
    end
    return win;
  endfunction

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  logic [3:0] lvl_r [3]; // fixed priority levels
  logic [3:0] lvl_nxt [3];
  logic enable_r, enable_nxt; // weighted-token scheme on
  logic [15:0] period_r, period_nxt; // refresh period length
  logic [15:0] budget_r [3]; // token budgets as software wrote them
  logic [15:0] budget_nxt [3];
  logic [31:0] prdata_r, prdata_nxt; // read data, set in setup phase
  logic pready_r, pready_nxt; // answer in the first access cycle
  logic pslverr_r, pslverr_nxt; // unmapped address
  logic [2:0] tok_ok; // per-master token class
  logic [2:0] grant_r, grant_nxt; // current bus owner, one-hot
  wtba_sel_t sel; // register under the current address
  logic wr_take; // write lands this edge

  assign sel = decode(apb_req.paddr);
  assign wr_take = apb_req.psel && apb_req.penable && pready_r && apb_req.pwrite;

  // register next values and the read answer
  always_comb begin
    lvl_nxt = lvl_r;
    enable_nxt = enable_r;
    period_nxt = period_r;
    budget_nxt = budget_r;
    prdata_nxt = prdata_r;
    pslverr_nxt = 1'b0;
    pready_nxt = 1'b0;
    // setup phase: prepare the answer so data comes from flops
    if (apb_req.psel && !apb_req.penable) begin
      pready_nxt = 1'b1;
      pslverr_nxt = (sel == WTBA_SEL_NONE);
      prdata_nxt = 32'h0000_0000;
      if (!apb_req.pwrite) begin
        if (sel == WTBA_SEL_LVL0) begin
          prdata_nxt[3:0] = lvl_r[0];
        end else if (sel == WTBA_SEL_LVL1) begin
          prdata_nxt[3:0] = lvl_r[1];
        end else if (sel == WTBA_SEL_LVL2) begin
          prdata_nxt[3:0] = lvl_r[2];
        end else if (sel == WTBA_SEL_ENABLE) begin
          prdata_nxt[`WTBA_EN_BIT] = enable_r;
        end else if (sel == WTBA_SEL_PERIOD) begin
          prdata_nxt[15:0] = period_r;
        end else if (sel == WTBA_SEL_TOK0) begin
          prdata_nxt[15:0] = budget_r[0];
        end else if (sel == WTBA_SEL_TOK1) begin
          prdata_nxt[15:0] = budget_r[1];
        end else if (sel == WTBA_SEL_TOK2) begin
          prdata_nxt[15:0] = budget_r[2];
        end else if (sel == WTBA_SEL_STATUS) begin
          // live view of token classes and the bus owner
          prdata_nxt[`WTBA_ST_TOK_LSB +: 3] = tok_ok;
          prdata_nxt[`WTBA_ST_GNT_LSB +: 3] = grant_r;
        end
      end
    end
    // writes take effect only at the completing edge
    if (wr_take) begin
      if (sel == WTBA_SEL_LVL0) begin
        lvl_nxt[0] = apb_req.pwdata[3:0];
      end else if (sel == WTBA_SEL_LVL1) begin
        lvl_nxt[1] = apb_req.pwdata[3:0];
      end else if (sel == WTBA_SEL_LVL2) begin
        lvl_nxt[2] = apb_req.pwdata[3:0];
      end else if (sel == WTBA_SEL_ENABLE) begin
        enable_nxt = apb_req.pwdata[`WTBA_EN_BIT];
      end else if (sel == WTBA_SEL_PERIOD) begin
        period_nxt = apb_req.pwdata[15:0];
      end else if (sel == WTBA_SEL_TOK0) begin
        budget_nxt[0] = apb_req.pwdata[15:0];
      end else if (sel == WTBA_SEL_TOK1) begin
        budget_nxt[1] = apb_req.pwdata[15:0];
      end else if (sel == WTBA_SEL_TOK2) begin
        budget_nxt[2] = apb_req.pwdata[15:0];
      end
    end
  end

  // register storage, reset to the documented defaults
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      lvl_r[0] <= `WTBA_RST_LVL_CPU;
      lvl_r[1] <= `WTBA_RST_LVL_PCIE;
      lvl_r[2] <= `WTBA_RST_LVL_CSR;
      enable_r <= `WTBA_RST_ENABLE;
      period_r <= `WTBA_RST_PERIOD;
      for (int i = 0; i < 3; i++) begin
        budget_r[i] <= `WTBA_RST_TOKENS;
      end
      prdata_r <= 32'h0000_0000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      lvl_r <= lvl_nxt;
      enable_r <= enable_nxt;
      period_r <= period_nxt;
      budget_r <= budget_nxt;
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  assign apb_rsp.prdata = prdata_r;
  assign apb_rsp.pready = pready_r;
  assign apb_rsp.pslverr = pslverr_r;

  // ----------------------------------------------------------------
  // refresh period
  // ----------------------------------------------------------------
  logic [15:0] per_cnt_r, per_cnt_nxt; // cycles left in this period
  logic enable_d_r, enable_d_nxt; // enable one cycle ago
  logic refresh; // start of a new period

  // a fresh enable starts a period at once, so no stale counts linger
  assign refresh = enable_r && (!enable_d_r || per_cnt_r == 16'h0000);

  always_comb begin
    enable_d_nxt = enable_r;
    per_cnt_nxt = per_cnt_r;
    if (refresh) begin
      // period 0 behaves as 1: a refresh every cycle
      per_cnt_nxt = (period_r == 16'h0000) ? 16'h0000
                                           : 16'(period_r - 16'h0001);
    end else if (enable_r) begin
      per_cnt_nxt = 16'(per_cnt_r - 16'h0001);
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      per_cnt_r <= 16'h0000;
      enable_d_r <= 1'b0;
    end else begin
      per_cnt_r <= per_cnt_nxt;
      enable_d_r <= enable_d_nxt;
    end
  end

  // ----------------------------------------------------------------
  // token counters, one per master
  // ----------------------------------------------------------------
  logic [2:0] use_bus; // owner still requesting: a bus-use cycle
  logic [2:0] has_tok; // raw token state from the counters
  logic [15:0] tokens [3]; // tokens left, for checking
  logic [15:0] live [3]; // budgets in force, for checking

  assign use_bus = grant_r & bus_req & {3{enable_r}};
  // disabled scheme puts every master in one class
  assign tok_ok = enable_r ? has_tok : 3'b111;

  for (genvar g = 0; g < 3; g++) begin : g_tok
    wtba_token_ctr u_ctr (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .refresh(refresh),
      .budget(budget_r[g]),
      .use_bus(use_bus[g]),
      .tokens(tokens[g]),
      .budget_live(live[g]),
      .has_tokens(has_tok[g])
    );
  end

  // ----------------------------------------------------------------
  // grant
  // ----------------------------------------------------------------
  logic arb; // arbitration point: bus free or owner let go

  // the owner keeps the bus while it requests; demotion shows at the
  // next arbitration point, never by pulling a grant mid-transfer
  assign arb = (grant_r & bus_req) == 3'b000;

  always_comb begin
    grant_nxt = grant_r;
    if (arb) begin
      grant_nxt = pick(bus_req, tok_ok, {lvl_r[2], lvl_r[1], lvl_r[0]});
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      grant_r <= 3'b000;
    end else begin
      grant_r <= grant_nxt;
    end
  end

  assign bus_grant = grant_r;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  AST_RELOAD: assert property (refresh |=> tokens[1] == live[1])
    else $error("token counter not reloaded at refresh");
  AST_PERIOD: assert property (
    refresh && period_r > 16'h0002 |=> !refresh [*2] ##0 per_cnt_r == $past(period_r, 2) - 2
  )
    else $error("refresh period length wrong");
  AST_SPEND: assert property (
    use_bus[0] && tokens[0] != 16'h0000 && !refresh |=> tokens[0] == $past(tokens[0]) - 1
  )
    else $error("token not spent on bus use");
  AST_DEMOTE: assert property (
    enable_r && tokens[0] == 16'h0000 && live[0] != 16'h0000 |-> !tok_ok[0]
  )
    else $error("exhausted master not demoted");
  AST_TOKEN_FIRST: assert property (
    arb && |(bus_req & tok_ok) |=> |(grant_r & $past(tok_ok))
  )
    else $error("exhausted master beat a token holder");
  AST_DISABLED_HOLD: assert property (
    !enable_r ##1 !enable_r |-> $stable(tokens[0]) && $stable(per_cnt_r)
  )
    else $error("token logic moved while disabled");
  AST_BUDGET_WRITE: assert property (
    wr_take && sel == WTBA_SEL_TOK1 |=> budget_r[1] == $past(apb_req.pwdata[15:0])
  )
    else $error("budget write lost");
  AST_UNLIMITED: assert property (live[1] == 16'h0000 |-> tok_ok[1])
    else $error("zero budget master demoted");
  AST_LEVEL: assert property (
    arb && !enable_r && bus_req[1] && bus_req[2] && lvl_r[1] > lvl_r[2] |=> !grant_r[2]
  )
    else $error("lower level won");
  // a grant has at most one bit set and is always backed by a request one cycle earlier
  AST_ONE_OWNER: assert property ($onehot0(grant_r) && (grant_r & ~$past(bus_req)) == 3'b000)
    else $error("grant not one-hot or given without request");
  AST_LATE_BUDGET: assert property (
    !$past(refresh) && $changed(budget_r[0]) |-> $stable(live[0])
  )
    else $error("budget applied before refresh");

  CVR_REFRESH: cover property (refresh ##1 !refresh);
  CVR_EXHAUST: cover property (enable_r && !has_tok[0] && bus_req[0] && bus_req[1]);
  CVR_HANDOFF: cover property (grant_r[0] ##1 grant_r[1]);
  CVR_SLVERR: cover property (apb_rsp.pslverr && apb_rsp.pready);
endmodule // wtba_arbiter

// File: verif/wtba_master_model.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// three bus masters: each asks for the bus until it has had
// the number of granted cycles that the bench ordered
// ----------------------------------------------------------------
module wtba_master_model (
  // clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // orders from the bench
  input wire logic [2:0] go,
  input wire logic [7:0] len,
  // shared bus side
  input wire logic [2:0] bus_grant,
  output logic [2:0] bus_req,
  output logic busy
);
  logic [7:0] left_r [3]; // granted cycles still wanted

  // a master spends one cycle of its order only when it both asks and owns
  always_ff @(posedge core_clk or negedge arst_n) begin
    for (int i = 0; i < 3; i++) begin
      if (!arst_n) begin
        left_r[i] <= 8'h00;
      end else if (go[i]) begin
        left_r[i] <= len;
      end else if (bus_req[i] && bus_grant[i]) begin
        left_r[i] <= left_r[i] - 8'h01;
      end
    end
  end

  // request is a level held until the order is used up
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      bus_req[i] = (left_r[i] != 8'h00);
    end
  end

  assign busy = |bus_req;
endmodule // wtba_master_model

// File: verif/wtba_arbiter_tb.sv
`timescale 1ns/10ps
`include "wtba_consts.svh"
module wtba_arbiter_tb;
  import wtba_pkg::*;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic core_clk;
  logic arst_n;
  wtba_apb_req_t apb_req;
  wtba_apb_rsp_t apb_rsp;
  logic [2:0] bus_req;
  logic [2:0] bus_grant;
  logic [2:0] go; // start pulse per master
  logic [7:0] len; // granted cycles each master wants
  logic mdl_busy;
  int bad_count = 0;
  int checks_done = 0;
  int cyc = 0;
  int n;
  logic [31:0] q;
  logic e;

  wtba_arbiter wtba_arbiter_i (.core_clk(core_clk), .arst_n(arst_n), .apb_req(apb_req),
    .apb_rsp(apb_rsp), .bus_req(bus_req), .bus_grant(bus_grant));
  wtba_master_model wtba_master_model_i (.core_clk(core_clk), .arst_n(arst_n), .go(go),
    .len(len), .bus_grant(bus_grant), .bus_req(bus_req), .busy(mdl_busy));

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // a hang ends the run through the same report
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      close_out();
    end
  end

  task automatic chk(input string name, input logic [31:0] x, input logic [31:0] s);
    checks_done++;
    if (s !== x) begin
      bad_count++;
      $display("Error %s expected %h seen %h", name, x, s);
    end
  endtask

  // one apb transfer; waits an edge first so no signal is set twice in a step
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] rd_q, output logic err);
    int k;
    k = 0;
    @(posedge core_clk);
    apb_req.psel <= 1'b1;
    apb_req.penable <= 1'b0;
    apb_req.pwrite <= wr;
    apb_req.paddr <= a;
    apb_req.pwdata <= d;
    @(posedge core_clk);
    apb_req.penable <= 1'b1;
    do begin
      @(posedge core_clk);
      k++;
    end while (apb_rsp.pready !== 1'b1);
    rd_q = apb_rsp.prdata;
    err = apb_rsp.pslverr;
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
    chk("pready", 32'h1, {31'h0, apb_rsp.pready});
    // the slave answers in the first access cycle, no wait states
    chk("pready wait", 32'h1, k);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    logic [31:0] d;
    logic er;
    apb(1'b0, a, 32'h0, d, er);
    chk("read data", x, d);
    chk("read pslverr", 32'h0, {31'h0, er});
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] d2;
    logic er;
    apb(1'b1, a, d, d2, er);
    chk("write pslverr", 32'h0, {31'h0, er});
  endtask

  // start masters, record each new owner; grant is looked at settled, on the low phase
  task automatic run(input logic [2:0] m, input logic [7:0] l, input logic [8:0] x);
    logic [8:0] seen;
    logic [2:0] last;
    int k;
    seen = '0;
    last = '0;
    k = 0;
    @(posedge core_clk);
    go <= m;
    len <= l;
    @(posedge core_clk);
    go <= 3'h0;
    do begin
      @(negedge core_clk);
      k++;
      if (bus_grant !== 3'h0 && bus_grant !== last) begin
        seen = {seen[5:0], bus_grant};
        last = bus_grant;
      end
    end while (mdl_busy === 1'b1 && k < 300);
    // a run that ran out of time counts as a mismatch
    chk("masters done", 32'h0, {31'h0, mdl_busy});
    chk("grant order", {23'h0, x}, {23'h0, seen});
  endtask

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    arst_n = 1'b0;
    apb_req = '0;
    go = 3'h0;
    len = 8'h00;
    repeat (6) @(posedge core_clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge core_clk);

    // reset values; status shows all in one class while the scheme is off
    rd(`WTBA_OFS_LVL_CPU, 32'h0000000e);
    rd(`WTBA_OFS_LVL_PCIE, 32'h0000000d);
    rd(`WTBA_OFS_LVL_CSR, 32'h0000000c);
    rd(`WTBA_OFS_ENABLE, 32'h00000000);
    rd(`WTBA_OFS_PERIOD, 32'h0000ffff);
    rd(`WTBA_OFS_TOK_CPU, 32'h00000fff);
    rd(`WTBA_OFS_TOK_PCIE, 32'h00000fff);
    rd(`WTBA_OFS_TOK_CSR, 32'h00000fff);
    rd(`WTBA_OFS_STATUS, 32'h00000007);
    // unmapped place is refused both ways
    apb(1'b1, 12'h064, 32'h5, q, e);
    chk("unmapped write pslverr", 32'h1, {31'h0, e});
    apb(1'b0, 12'h064, 32'h0, q, e);
    chk("unmapped read pslverr", 32'h1, {31'h0, e});
    chk("unmapped read data", 32'h0, q);
    $display("test registers done");

    // scheme off: fixed levels only
    run(3'h7, 8'h02, {3'h1, 3'h2, 3'h4});
    wr(`WTBA_OFS_LVL_CPU, 32'h0000000f);
    wr(`WTBA_OFS_LVL_PCIE, 32'h00000001);
    wr(`WTBA_OFS_LVL_CSR, 32'h00000002);
    run(3'h7, 8'h02, {3'h1, 3'h4, 3'h2});
    $display("test fixed priority done");

    // scheme on: cpu 4 tokens, pcie unlimited, csr 20, period 300
    wr(`WTBA_OFS_PERIOD, 32'habcd012c);
    rd(`WTBA_OFS_PERIOD, 32'h0000012c);
    wr(`WTBA_OFS_TOK_CPU, 32'h00000004);
    wr(`WTBA_OFS_TOK_PCIE, 32'h00000000);
    wr(`WTBA_OFS_TOK_CSR, 32'h00000014);
    rd(`WTBA_OFS_TOK_CPU, 32'h00000004);
    wr(`WTBA_OFS_ENABLE, 32'hffffffff);
    rd(`WTBA_OFS_ENABLE, 32'h00000001);
    run(3'h1, 8'h03, {6'h0, 3'h1});
    rd(`WTBA_OFS_STATUS, 32'h00000007);
    run(3'h3, 8'h28, {3'h0, 3'h1, 3'h2});
    rd(`WTBA_OFS_STATUS, 32'h00000006);
    run(3'h7, 8'h02, {3'h4, 3'h2, 3'h1});
    $display("test token spend done");

    // tokens come back at the next period boundary
    n = 0;
    q = 32'h0;
    while (q !== 32'h7 && n < 200) begin
      apb(1'b0, `WTBA_OFS_STATUS, 32'h0, q, e);
      n++;
    end
    chk("status after refresh", 32'h7, q);
    run(3'h7, 8'h02, {3'h1, 3'h4, 3'h2});
    $display("test refresh done");
    close_out();
  end
endmodule // wtba_arbiter_tb
